// file: core/dws_pkg.sv
// package: constants for the dual watch and selective call controller
package dws_pkg;
    localparam int unsigned CLK_HZ        = 40000000;
    localparam int unsigned WATCH_PERIOD_S = 5;
    localparam int unsigned PRIO_DWELL_S   = 2;
    localparam int unsigned DROP_HOLD_S    = 5;
    localparam int unsigned TIME_HOLD_S    = 10;
    localparam int unsigned RECHECK_S      = 5;
    localparam int unsigned ARM_PRESS_MS   = 500;
    localparam int unsigned BLINK_MS       = 250;
    localparam int unsigned ARM_CYCLES     = CLK_HZ / 1000 * ARM_PRESS_MS;
    localparam int unsigned BLINK_CYCLES   = CLK_HZ / 1000 * BLINK_MS;
    localparam int unsigned DIGITS         = 4;
    localparam logic [15:0] CODE_RESET     = 16'h1111;

    // wishbone register offsets
    localparam logic [7:0] CTRL_ADDR   = 8'h00;
    localparam logic [7:0] STATUS_ADDR = 8'h04;
    localparam logic [7:0] IRQ_ADDR    = 8'h08;
    localparam logic [7:0] MASK_ADDR   = 8'h0C;
    localparam logic [7:0] CODE_ADDR   = 8'h10;
    localparam logic [7:0] PAGE_ADDR   = 8'h14;

    // control fields
    localparam int unsigned CTRL_DROP_BIT = 0;
    localparam int unsigned CTRL_PVAL_BIT = 1;
    localparam int unsigned CTRL_DIST_BIT = 2;
    localparam int unsigned CTRL_SSB_BIT  = 3;
    localparam logic [3:0]  CTRL_RESET    = 4'h1;

    // irq bits
    localparam int unsigned IRQ_HOLD_BIT   = 0;
    localparam int unsigned IRQ_PAGE_BIT   = 1;
    localparam int unsigned IRQ_REJECT_BIT = 2;
    localparam int unsigned IRQ_W          = 3;

    typedef enum logic [2:0] {
        DWS_OFF, DWS_WORK, DWS_PRIO, DWS_HOLD_ON, DWS_HOLD_TAIL,
        DWS_TIME_HOLD, DWS_RECHECK
    } dws_watch_e;

    typedef enum logic [1:0] {
        DWS_SC_IDLE, DWS_SC_ARMED, DWS_SC_ALARM
    } dws_sc_e;
endpackage : dws_pkg

// file: core/dws_control.sv
// dual watch sequencer and selective-call receive controller
`timescale 1ns/1ps
`default_nettype none
module dws_control
    import dws_pkg::*;
#(
    parameter int unsigned TICK_CYCLES = dws_pkg::CLK_HZ
) (
    input  wire logic        MCLK,
    input  wire logic        RST_N,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [7:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic        WATCH_KEY,
    input  wire logic        CALL_KEY,
    input  wire logic        SQUELCH_OPEN,
    input  wire logic        PTT,
    input  wire logic        PAGE_VALID,
    input  wire logic [15:0] PAGE_CODE,
    input  wire logic        CHAN_REQ,
    input  wire logic [7:0]  CHAN_NUM,
    output logic             ON_PRIORITY,
    output logic             WATCH_ACTIVE,
    output logic [7:0]       WORK_CHAN,
    output logic             RX_MUTE,
    output logic             CALL_LAMP,
    output logic             ALARM,
    output logic             SHOW_CODE,
    output logic             TX_KEY,
    output logic             IRQ
);
    import dws_pkg::*;

    // ------------------------------------------------------------------
    // digit decoding for own code checks and page matching
    // ------------------------------------------------------------------
    function automatic logic code_ok(input logic [15:0] c);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < DIGITS; i++) begin
            if (c[i*4 +: 4] == 4'h0 || c[i*4 +: 4] > 4'h9) begin
                ok = 1'b0;
            end
        end
        return ok;
    endfunction : code_ok

    function automatic logic code_match(input logic [15:0] rx,
                                        input logic [15:0] own);
        logic m;
        m = 1'b1;
        for (int i = 0; i < DIGITS; i++) begin
            if (rx[i*4 +: 4] != 4'h0 && rx[i*4 +: 4] != own[i*4 +: 4]) begin
                m = 1'b0;
            end
        end
        return m;
    endfunction : code_match

    // ------------------------------------------------------------------
    // registers and bus slave
    // ------------------------------------------------------------------
    logic [3:0]       ctrl_reg;
    logic [15:0]      own_call_code_reg;
    logic [IRQ_W-1:0] irq_reg;
    logic [IRQ_W-1:0] irq_next;
    logic [IRQ_W-1:0] mask_reg;
    logic [IRQ_W-1:0] ev_set;
    logic [15:0]      page_reg;
    dws_watch_e       watch_reg;
    dws_sc_e          sc_reg;
    logic             wb_hit;
    logic             irq_rd;
    logic             carrier_drop_setting;

    assign wb_hit = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign irq_rd = wb_hit && !WB_WE_I && WB_ADR_I == IRQ_ADDR;
    assign carrier_drop_setting = ctrl_reg[CTRL_DROP_BIT];

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            WB_ACK_O <= 1'b0;
        end else begin
            WB_ACK_O <= wb_hit;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            ctrl_reg <= CTRL_RESET;
        end else if (wb_hit && WB_WE_I && WB_SEL_I[0]
                     && WB_ADR_I == CTRL_ADDR) begin
            ctrl_reg <= WB_DAT_I[3:0];
        end
    end

    // own code write with a zero or non-decimal digit is refused
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            own_call_code_reg <= CODE_RESET;
        end else if (wb_hit && WB_WE_I && WB_SEL_I[1:0] == 2'h3
                     && WB_ADR_I == CODE_ADDR
                     && code_ok(WB_DAT_I[15:0])) begin
            own_call_code_reg <= WB_DAT_I[15:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            mask_reg <= '0;
        end else if (wb_hit && WB_WE_I && WB_SEL_I[0]
                     && WB_ADR_I == MASK_ADDR) begin
            mask_reg <= WB_DAT_I[IRQ_W-1:0];
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            page_reg <= '0;
        end else if (PAGE_VALID) begin
            page_reg <= PAGE_CODE;
        end
    end

    // read clear; an event in the same cycle survives
    always_comb begin
        irq_next = (irq_rd ? '0 : irq_reg) | ev_set;
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            irq_reg <= '0;
            IRQ     <= 1'b0;
        end else begin
            irq_reg <= irq_next;
            IRQ     <= |(irq_next & mask_reg);
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            WB_DAT_O <= '0;
        end else if (wb_hit && !WB_WE_I) begin
            unique case (WB_ADR_I)
                CTRL_ADDR:   WB_DAT_O <= {28'h0, ctrl_reg};
                STATUS_ADDR: WB_DAT_O <= {24'h0, 1'b0, watch_reg,
                                          sc_reg, WATCH_ACTIVE, ON_PRIORITY};
                IRQ_ADDR:    WB_DAT_O <= {29'h0, irq_reg};
                MASK_ADDR:   WB_DAT_O <= {29'h0, mask_reg};
                CODE_ADDR:   WB_DAT_O <= {16'h0, own_call_code_reg};
                PAGE_ADDR:   WB_DAT_O <= {16'h0, page_reg};
                default:     WB_DAT_O <= '0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // one-second timebase
    // ------------------------------------------------------------------
    logic [25:0] div_reg;
    logic        sec_tick;
    logic [3:0]  sec_reg;
    logic        sec_clr;

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            div_reg  <= '0;
            sec_tick <= 1'b0;
        end else if (div_reg == 26'(TICK_CYCLES - 1)) begin
            div_reg  <= '0;
            sec_tick <= 1'b1;
        end else begin
            div_reg  <= div_reg + 26'h1;
            sec_tick <= 1'b0;
        end
    end

    // seconds spent in the current watch state
    always_ff @(posedge MCLK) begin
        if (!RST_N || sec_clr) begin
            sec_reg <= '0;
        end else if (sec_tick) begin
            sec_reg <= sec_reg + 4'h1;
        end
    end

    // ------------------------------------------------------------------
    // dual watch sequencer
    // ------------------------------------------------------------------
    logic       watch_key_q;
    logic       watch_press;
    logic       prio_valid;
    dws_watch_e watch_next;

    assign prio_valid  = ctrl_reg[CTRL_PVAL_BIT];
    assign watch_press = WATCH_KEY && !watch_key_q;

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            watch_key_q <= 1'b0;
        end else begin
            watch_key_q <= WATCH_KEY;
        end
    end

    // distress mode bit does not block activation
    always_comb begin
        watch_next = watch_reg;
        if (!prio_valid) begin
            watch_next = DWS_OFF;
        end else if (watch_press) begin
            watch_next = (watch_reg == DWS_OFF) ? DWS_WORK : DWS_OFF;
        end else if (sec_tick) begin
            unique case (watch_reg)
                DWS_OFF: watch_next = DWS_OFF;
                DWS_WORK, DWS_RECHECK: begin
                    if (sec_reg == 4'(WATCH_PERIOD_S - 1)) begin
                        watch_next = DWS_PRIO;
                    end
                end
                DWS_PRIO: begin
                    if (SQUELCH_OPEN) begin
                        watch_next = carrier_drop_setting ?
                                     DWS_HOLD_ON : DWS_TIME_HOLD;
                    end else if (sec_reg == 4'(PRIO_DWELL_S - 1)) begin
                        watch_next = DWS_WORK;
                    end
                end
                DWS_HOLD_ON: begin
                    if (!SQUELCH_OPEN) begin
                        watch_next = DWS_HOLD_TAIL;
                    end
                end
                DWS_HOLD_TAIL: begin
                    if (SQUELCH_OPEN) begin
                        watch_next = DWS_HOLD_ON;
                    end else if (sec_reg == 4'(DROP_HOLD_S - 1)) begin
                        watch_next = DWS_WORK;
                    end
                end
                DWS_TIME_HOLD: begin
                    if (sec_reg == 4'(TIME_HOLD_S - 1)) begin
                        watch_next = DWS_RECHECK;
                    end
                end
            endcase
        end
    end

    assign sec_clr = watch_next != watch_reg || watch_press;

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            watch_reg    <= DWS_OFF;
            ON_PRIORITY  <= 1'b0;
            WATCH_ACTIVE <= 1'b0;
        end else begin
            watch_reg    <= watch_next;
            ON_PRIORITY  <= watch_next inside {DWS_PRIO, DWS_HOLD_ON,
                                               DWS_HOLD_TAIL, DWS_TIME_HOLD};
            WATCH_ACTIVE <= watch_next != DWS_OFF;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            WORK_CHAN <= '0;
        end else if (CHAN_REQ && watch_reg != DWS_PRIO) begin
            WORK_CHAN <= CHAN_NUM;
        end
    end

    // ------------------------------------------------------------------
    // selective call receive
    // ------------------------------------------------------------------
    // hold and blink lengths follow the tick, so a short sim tick scales them
    localparam longint unsigned ARM_CNT   = longint'(ARM_CYCLES) * TICK_CYCLES
                                            / CLK_HZ;
    localparam longint unsigned BLINK_CNT = longint'(BLINK_CYCLES) * TICK_CYCLES
                                            / CLK_HZ;

    logic [24:0] press_reg;
    logic        call_key_q;
    logic        long_hit;
    logic        ptt_q;
    logic [23:0] blink_reg;
    logic        blink_ph;
    logic        page_hit;

    assign long_hit = CALL_KEY && press_reg == 25'(ARM_CNT - 1);
    assign page_hit = PAGE_VALID && sc_reg == DWS_SC_ARMED
                      && code_match(PAGE_CODE, own_call_code_reg);

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            press_reg  <= '0;
            call_key_q <= 1'b0;
            ptt_q      <= 1'b0;
        end else begin
            call_key_q <= CALL_KEY;
            ptt_q      <= PTT;
            if (!CALL_KEY) begin
                press_reg <= '0;
            end else if (press_reg != 25'(ARM_CNT)) begin
                press_reg <= press_reg + 25'h1;
            end
        end
    end

    // arming only in voice sideband; PTT after alarm drops to normal rx
    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            sc_reg <= DWS_SC_IDLE;
        end else begin
            unique case (sc_reg)
                DWS_SC_IDLE: begin
                    if (long_hit && ctrl_reg[CTRL_SSB_BIT]) begin
                        sc_reg <= DWS_SC_ARMED;
                    end
                end
                DWS_SC_ARMED: begin
                    if (page_hit) begin
                        sc_reg <= DWS_SC_ALARM;
                    end else if (!ctrl_reg[CTRL_SSB_BIT]) begin
                        sc_reg <= DWS_SC_IDLE;
                    end
                end
                DWS_SC_ALARM: begin
                    if (PTT && !ptt_q) begin
                        sc_reg <= DWS_SC_IDLE;
                    end
                end
                default: sc_reg <= DWS_SC_IDLE;
            endcase
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            blink_reg <= '0;
            blink_ph  <= 1'b0;
        end else if (blink_reg == 24'(BLINK_CNT - 1)) begin
            blink_reg <= '0;
            blink_ph  <= !blink_ph;
        end else begin
            blink_reg <= blink_reg + 24'h1;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RST_N) begin
            RX_MUTE   <= 1'b0;
            CALL_LAMP <= 1'b0;
            ALARM     <= 1'b0;
            SHOW_CODE <= 1'b0;
            TX_KEY    <= 1'b0;
        end else begin
            RX_MUTE   <= sc_reg == DWS_SC_ARMED;
            CALL_LAMP <= sc_reg == DWS_SC_ARMED
                         || (sc_reg == DWS_SC_ALARM && blink_ph);
            ALARM     <= sc_reg == DWS_SC_ALARM;
            SHOW_CODE <= CALL_KEY && ctrl_reg[CTRL_SSB_BIT];
            TX_KEY    <= PTT && sc_reg == DWS_SC_IDLE;
        end
    end

    // events
    always_comb begin
        ev_set = '0;
        ev_set[IRQ_HOLD_BIT]   = watch_reg == DWS_PRIO
                                 && watch_next inside {DWS_HOLD_ON,
                                                       DWS_TIME_HOLD};
        ev_set[IRQ_PAGE_BIT]   = page_hit;
        ev_set[IRQ_REJECT_BIT] = wb_hit && WB_WE_I && WB_ADR_I == CODE_ADDR
                                 && !code_ok(WB_DAT_I[15:0]);
    end

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    sequence prio_quiet_s;
        watch_reg == DWS_PRIO && sec_tick && !SQUELCH_OPEN
        && sec_reg == 4'(PRIO_DWELL_S - 1) && !watch_press && prio_valid;
    endsequence

    no_prio_invalid_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        !prio_valid |=> watch_reg == DWS_OFF)
        else $error("watch active with empty priority slot");
    dwell_return_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        prio_quiet_s |=> watch_reg == DWS_WORK ##1 !ON_PRIORITY)
        else $error("priority dwell did not return");
    hold_drop_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        watch_reg == DWS_HOLD_ON && SQUELCH_OPEN && prio_valid
        && !watch_press |=> watch_reg == DWS_HOLD_ON)
        else $error("carrier hold left early");
    tail_len_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        watch_reg == DWS_HOLD_TAIL && sec_reg > 4'(DROP_HOLD_S - 1)
        |-> 1'b0)
        else $error("carrier tail overran");
    time_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        watch_reg == DWS_TIME_HOLD && $changed(watch_reg) && prio_valid
        |-> sec_reg == 4'h0)
        else $error("time hold not started at zero");
    mute_armed_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        sc_reg == DWS_SC_ARMED |=> RX_MUTE)
        else $error("armed without mute");
    page_alarm_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        page_hit |=> sc_reg == DWS_SC_ALARM ##1 ALARM)
        else $error("matched page raised no alarm");
    ptt_cancel_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        sc_reg == DWS_SC_ALARM && PTT && !ptt_q
        |=> sc_reg == DWS_SC_IDLE ##1 !RX_MUTE)
        else $error("ptt did not cancel alarm");
    chan_lock_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        watch_reg == DWS_PRIO |=> $stable(WORK_CHAN))
        else $error("channel changed during sampling");
endmodule : dws_control
`default_nettype wire

// file: dv/dws_operator.sv
// operator side model: keys, squelch detector and push-to-talk
`timescale 1ns/1ps
`default_nettype none
module dws_operator (
    input  wire logic       clk,
    output logic            watch_key,
    output logic            call_key,
    output logic            squelch_open,
    output logic            ptt,
    output logic            chan_req,
    output logic [7:0]      chan_num,
    output logic            page_valid,
    output logic [15:0]     page_code
);
    // ------------------------------
    // idle levels
    // ------------------------------
    initial begin
        watch_key = 1'b0;
        call_key = 1'b0;
        squelch_open = 1'b0;
        ptt = 1'b0;
        chan_req = 1'b0;
        chan_num = 8'h00;
        page_valid = 1'b0;
        page_code = 16'h0000;
    end
    // one decoded page from the tone receiver, valid for one cycle
    task automatic page(input logic [15:0] c);
        @(posedge clk);
        page_valid <= 1'b1;
        page_code <= c;
        @(posedge clk);
        page_valid <= 1'b0;
    endtask : page
    // index 0 watch, 1 call, 2 squelch, 3 push-to-talk
    task automatic set(input int k, input logic v);
        @(posedge clk);
        case (k)
            0: watch_key <= v;
            1: call_key <= v;
            2: squelch_open <= v;
            default: ptt <= v;
        endcase
    endtask : set
    // channel number is stale after the strobe, so scramble it
    task automatic chan(input logic [7:0] n);
        @(posedge clk);
        chan_req <= 1'b1;
        chan_num <= n;
        @(posedge clk);
        chan_req <= 1'b0;
        chan_num <= ~n;
    endtask : chan
endmodule : dws_operator
`default_nettype wire

// file: dv/testbench.sv
// self-checking bench for the dual watch and selective call controller
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import dws_pkg::*;
    // ------------------------------
    // signals
    // ------------------------------
    localparam int T = 20;
    logic        mclk = 1'b0;
    logic        rst_n = 1'b0;
    logic        cyc = 1'b0;
    logic        stb = 1'b0;
    logic        we = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wdat = 32'h0;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        ack;
    logic        wkey, ckey, sq, ptt, creq;
    logic        pv;
    logic [15:0] pcode;
    logic [7:0]  cnum;
    logic [7:0]  wchan;
    logic        on_prio, w_act, mute, lamp, alarm, show, tx, irq;
    logic        a;
    int          n;
    int          error_cnt = 0;
    int          compares = 0;

    always #12.5 mclk = ~mclk;

    dws_control #(.TICK_CYCLES(T)) dws_control_inst (
        .MCLK(mclk), .RST_N(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF), .WB_DAT_I(wdat),
        .WB_DAT_O(rdat), .WB_ACK_O(ack), .WATCH_KEY(wkey),
        .CALL_KEY(ckey), .SQUELCH_OPEN(sq), .PTT(ptt),
        .PAGE_VALID(pv), .PAGE_CODE(pcode), .CHAN_REQ(creq),
        .CHAN_NUM(cnum), .ON_PRIORITY(on_prio), .WATCH_ACTIVE(w_act),
        .WORK_CHAN(wchan), .RX_MUTE(mute), .CALL_LAMP(lamp),
        .ALARM(alarm), .SHOW_CODE(show), .TX_KEY(tx), .IRQ(irq)
    );

    dws_operator dws_operator_inst (
        .clk(mclk), .watch_key(wkey), .call_key(ckey),
        .squelch_open(sq), .ptt(ptt), .chan_req(creq), .chan_num(cnum),
        .page_valid(pv), .page_code(pcode)
    );

    // ------------------------------
    // tasks
    // ------------------------------
    task automatic wb(input logic w, input logic [7:0] ad,
                      input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= d;
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask : wb

    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic rng(input string nm, input int lo, input int hi);
        compares++;
        if (n < lo || n > hi) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0d..%0d seen %0d",
                     nm, lo, hi, n);
        end
    endtask : rng

    // cycles until the priority flag reaches v, bounded
    task automatic wprio(input logic v);
        n = 0;
        while (on_prio !== v && n < 1000) begin
            @(posedge mclk);
            n++;
        end
    endtask : wprio

    task automatic tap(input int k, input int c);
        dws_operator_inst.set(k, 1'b1);
        repeat (c) @(posedge mclk);
        dws_operator_inst.set(k, 1'b0);
        repeat (3) @(posedge mclk);
    endtask : tap

    task automatic results;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : results

    // ------------------------------
    // tests
    // ------------------------------
    initial begin
        repeat (5) @(posedge mclk);
        chk("reset outs", 32'h0, {on_prio, w_act, wchan, mute, lamp,
            alarm, show, tx, irq, ack});
        rst_n <= 1'b1;
        wb(1'b0, CTRL_ADDR, 32'h0);
        chk("ctrl reset", 32'h1, q);
        wb(1'b0, CODE_ADDR, 32'h0);
        chk("code reset", 32'h1111, q);
        wb(1'b0, 8'h40, 32'h0);
        chk("unmapped", 32'h0, q);
        tap(0, 2);
        chk("empty slot", 32'h0, w_act);
        $display("test reset done");

        wb(1'b1, CTRL_ADDR, 32'h3);
        tap(0, 2);
        chk("watch on", 32'h1, w_act);
        wprio(1'b1);
        rng("first visit", 3 * T, 6 * T);
        dws_operator_inst.chan(8'h22);
        repeat (3) @(posedge mclk);
        chk("chan in prio", 32'h0, wchan);
        wprio(1'b0);
        rng("dwell", T / 2, 3 * T);
        dws_operator_inst.chan(8'h33);
        repeat (3) @(posedge mclk);
        chk("chan in work", 32'h33, wchan);
        dws_operator_inst.set(2, 1'b1);
        wprio(1'b1);
        rng("period", 2 * T, 6 * T);
        repeat (8 * T) @(posedge mclk);
        chk("hold open", 32'h1, on_prio);
        wb(1'b1, MASK_ADDR, 32'h0);
        repeat (2) @(posedge mclk);
        a = irq;
        wb(1'b1, MASK_ADDR, 32'h7);
        repeat (2) @(posedge mclk);
        chk("irq masked", 32'h0, a);
        chk("irq mask", 32'h1, irq);
        wb(1'b0, IRQ_ADDR, 32'h0);
        chk("irq hold", 32'h1, q[IRQ_HOLD_BIT]);
        repeat (2) @(posedge mclk);
        chk("irq clear", 32'h0, irq);
        dws_operator_inst.set(2, 1'b0);
        wprio(1'b0);
        rng("drop tail", 4 * T, 7 * T);
        chk("resumed", 32'h1, w_act);
        chk("work chan", 32'h33, wchan);
        $display("test carrier drop done");

        wb(1'b1, CTRL_ADDR, 32'h2);
        dws_operator_inst.set(2, 1'b1);
        wprio(1'b1);
        repeat (2 * T) @(posedge mclk);
        dws_operator_inst.set(2, 1'b0);
        wprio(1'b0);
        rng("timed hold", 13 * T / 2, 9 * T);
        dws_operator_inst.set(2, 1'b1);
        wprio(1'b1);
        rng("recheck gap", 7 * T / 2, 6 * T);
        wprio(1'b0);
        rng("timed hold open", 9 * T, 11 * T);
        dws_operator_inst.set(2, 1'b0);
        tap(0, 2);
        chk("watch off", 32'h0, w_act);
        chk("off chan", 32'h33, wchan);
        repeat (7 * T) @(posedge mclk);
        chk("off no visit", 32'h0, on_prio);
        wb(1'b1, CTRL_ADDR, 32'h6);
        tap(0, 2);
        chk("distress on", 32'h1, w_act);
        tap(0, 2);
        $display("test time delay done");

        tap(1, T);
        chk("arm no voice", 32'h0, {mute, lamp});
        wb(1'b1, CTRL_ADDR, 32'h9);
        dws_operator_inst.set(1, 1'b1);
        repeat (3) @(posedge mclk);
        chk("show code", 32'h1, show);
        dws_operator_inst.set(1, 1'b0);
        repeat (3) @(posedge mclk);
        chk("not armed", 32'h0, {mute, lamp});
        wb(1'b1, CODE_ADDR, 32'h1203);
        wb(1'b0, CODE_ADDR, 32'h0);
        chk("zero digit", 32'h1111, q);
        wb(1'b0, IRQ_ADDR, 32'h0);
        chk("irq reject", 32'h1, q[IRQ_REJECT_BIT]);
        wb(1'b1, CODE_ADDR, 32'h1234);
        wb(1'b0, CODE_ADDR, 32'h0);
        chk("code ok", 32'h1234, q);
        tap(1, T);
        chk("armed", 32'h3, {mute, lamp});
        dws_operator_inst.page(16'h1235);
        repeat (3) @(posedge mclk);
        chk("no match", 32'h0, alarm);
        dws_operator_inst.page(16'h0234);
        repeat (3) @(posedge mclk);
        chk("alarm", 32'h1, alarm);
        n = 0;
        repeat (T) begin
            @(posedge mclk);
            if (lamp === 1'b1) n++;
        end
        rng("blink", T / 2 - 1, T / 2 + 1);
        wb(1'b0, STATUS_ADDR, 32'h0);
        chk("status alarm", 32'h8, q);
        wb(1'b0, PAGE_ADDR, 32'h0);
        chk("page code", 32'h0234, q);
        wb(1'b0, IRQ_ADDR, 32'h0);
        chk("irq page", 32'h1, q[IRQ_PAGE_BIT]);
        tap(3, 2);
        chk("cancel", 32'h0, {mute, alarm});
        dws_operator_inst.set(3, 1'b1);
        repeat (3) @(posedge mclk);
        chk("tx idle", 32'h1, tx);
        dws_operator_inst.set(3, 1'b0);
        repeat (3) @(posedge mclk);
        chk("no rearm", 32'h0, mute);
        $display("test selcall done");
        results();
    end

    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        results();
    end
endmodule : testbench
`default_nettype wire
